// ---- fbp_core.sv ----
/*
  flash array with per-block program and read protection, one-time
  clearable protection bits with commit, and microsecond timing.
  assumes all requests come from logic on the same clock; factory_rst
  stands for the delivered state of the nonvolatile protection copy.
*/
// Summary of operation
// - flash erases in 1-KB pages to ones
// - word program only clears bits
// - 2-KB blocks, two 32-bit protection registers
// - program-enable zero blocks program and erase
// - read-enable zero allows only instruction fetch
// - both zero means execute-only
// - program one, read zero: write, erase, execute
// - data reads checked against read policy
// - refused read returns no data, faults
// - protected program suppressed, interrupt if masked
// - timing from cycles-per-microsecond count
// - protection bits delivered as all ones
// - protection writes only clear bits, never set
// - uncommitted clears undone by power-on reset
// - writing one clears raw and masked flags
`timescale 1ns/1ps
`include "fbp_cfg.svh"

module fbp_core
#(
  parameter int FLASH_BYTES = `FBP_FLASH_BYTES,
  parameter int PROG_US = `FBP_PROG_US,
  parameter int ERASE_US = `FBP_ERASE_US,
  parameter int COMMIT_US = `FBP_COMMIT_US
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic factory_rst,
  input wire logic usec_wr,
  input wire logic [7:0] usec_wdata,
  output logic [7:0] usec_reload_count,
  input wire logic prot_wr,
  input wire logic prot_sel,
  input wire logic [31:0] prot_wdata,
  output logic [31:0] block_program_enable,
  output logic [31:0] block_read_enable,
  input wire fbp_pkg::fbp_rd_req_t rd_req,
  output logic rd_ready,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic rd_fault,
  input wire fbp_pkg::fbp_op_req_t op_req,
  output logic flash_busy,
  input wire logic commit_start,
  input wire logic commit_select,
  output logic commit_bit,
  input wire logic [1:0] flash_irq_mask_reg,
  input wire logic [1:0] flash_irq_status_clear,
  output logic [1:0] irq_raw,
  output logic [1:0] irq_masked
);
  import fbp_pkg::*;

  localparam int WORDS = FLASH_BYTES >> `FBP_WORD_SHIFT;
  localparam int PAGE_WORDS = 1 << (`FBP_PAGE_SHIFT - `FBP_WORD_SHIFT);
  localparam int WI_W = $clog2(WORDS);
  localparam int US_W = 12;
  // ****************************************
  // address decoding helpers
  // ****************************************
  function automatic logic [4:0] block_of(input logic [31:0] a);
    block_of = a[`FBP_BLOCK_SHIFT +: 5];
  endfunction
  function automatic logic [WI_W-1:0] word_of(input logic [31:0] a);
    word_of = a[`FBP_WORD_SHIFT +: WI_W];
  endfunction
  logic [31:0] mem [WORDS];
  logic [31:0] committed_pe;
  logic [31:0] committed_re;
  logic loaded;
  fbp_state_t state;
  fbp_state_t next_state;
  logic [US_W-1:0] us_count;
  logic [US_W-1:0] us_target;
  logic tick;
  logic [31:0] op_addr;
  logic [31:0] op_data;
  logic commit_reg;
  logic allowed;
  logic refused;
  logic done;
  logic [1:0] irq_set;
  // ****************************************
  // microsecond timing
  // ****************************************
  fbp_usec_timer #(.W(8)) u_timer (
    .clock(clock),
    .rst(rst),
    .restart(state == FBP_IDLE),
    .reload(usec_reload_count),
    .tick(tick)
  );
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      usec_reload_count <= `FBP_USEC_RESET;
    else if (usec_wr)
      usec_reload_count <= usec_wdata;
  end
  // ****************************************
  // operation sequencer
  // ****************************************
  assign allowed = loaded
                   && block_program_enable[block_of(op_req.addr)];
  assign refused = state == FBP_IDLE && op_req.cmd != FBP_CMD_NONE
                   && loaded && !allowed;
  assign done = state != FBP_IDLE && tick && us_count == us_target;
  always_comb
  begin
    next_state = state;
    case (state)
      FBP_IDLE:
      begin
        if (commit_start && loaded)
          next_state = FBP_COMMIT;
        else if (op_req.cmd == FBP_CMD_WRITE && allowed)
          next_state = FBP_PROG;
        else if (op_req.cmd == FBP_CMD_ERASE && allowed)
          next_state = FBP_ERASE;
      end
      default:
      begin
        if (done)
          next_state = FBP_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= FBP_IDLE;
      us_count <= '0;
      us_target <= '0;
      op_addr <= '0;
      op_data <= '0;
      commit_reg <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == FBP_IDLE)
      begin
        us_count <= 12'h001;
        op_addr <= op_req.addr;
        op_data <= op_req.data;
        commit_reg <= commit_select;
        if (commit_start)
          us_target <= US_W'(COMMIT_US);
        else if (op_req.cmd == FBP_CMD_ERASE)
          us_target <= US_W'(ERASE_US);
        else
          us_target <= US_W'(PROG_US);
      end
      else if (tick)
        us_count <= us_count + 1'b1;
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      flash_busy <= 1'b0;
      rd_ready <= 1'b0;
      commit_bit <= 1'b0;
    end
    else
    begin
      flash_busy <= next_state != FBP_IDLE;
      rd_ready <= next_state == FBP_IDLE;
      commit_bit <= next_state == FBP_COMMIT;
    end
  end
  // ****************************************
  // flash array
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (done && state == FBP_PROG)
      mem[word_of(op_addr)] <= mem[word_of(op_addr)] & op_data;
    else if (done && state == FBP_ERASE)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        if (i / PAGE_WORDS == int'(op_addr[31:`FBP_PAGE_SHIFT]))
          mem[i] <= 32'hFFFFFFFF;
      end
    end
  end

  // ****************************************
  // read path with protection check
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_done <= 1'b0;
      rd_data <= '0;
      rd_fault <= 1'b0;
    end
    else
    begin
      rd_done <= rd_req.valid && rd_ready;
      if (rd_req.valid && rd_ready)
      begin
        if (rd_req.kind != FBP_FETCH
            && !block_read_enable[block_of(rd_req.addr)])
        begin
          rd_data <= '0;
          rd_fault <= 1'b1;
        end
        else
        begin
          rd_data <= mem[word_of(rd_req.addr)];
          rd_fault <= 1'b0;
        end
      end
      else
        rd_fault <= 1'b0;
    end
  end
  // ****************************************
  // protection registers
  // ****************************************
  always_ff @(posedge clock or posedge factory_rst)
  begin
    if (factory_rst)
    begin
      committed_pe <= `FBP_PROT_RESET;
      committed_re <= `FBP_PROT_RESET;
    end
    else if (done && state == FBP_COMMIT)
    begin
      if (commit_reg)
        committed_pe <= committed_pe & block_program_enable;
      else
        committed_re <= committed_re & block_read_enable;
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      block_program_enable <= `FBP_PROT_RESET;
      block_read_enable <= `FBP_PROT_RESET;
      loaded <= 1'b0;
    end
    else if (!loaded)
    begin
      block_program_enable <= committed_pe;
      block_read_enable <= committed_re;
      loaded <= 1'b1;
    end
    else if (prot_wr)
    begin
      if (prot_sel)
        block_program_enable <= block_program_enable & prot_wdata;
      else
        block_read_enable <= block_read_enable & prot_wdata;
    end
  end

  // ****************************************
  // interrupt flags
  // ****************************************
  assign irq_set[`FBP_IRQ_PROG] = done && state != FBP_COMMIT;
  assign irq_set[`FBP_IRQ_ACCESS] = refused;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_raw <= '0;
      irq_masked <= '0;
    end
    else
    begin
      irq_raw <= irq_set | (irq_raw & ~flash_irq_status_clear);
      irq_masked <= (irq_set | (irq_raw & ~flash_irq_status_clear))
                    & flash_irq_mask_reg;
    end
  end

endmodule

// ---- fbp_cfg.svh ----
/*
  constants for the flash block protection and timing logic:
  offsets, field positions, reset values and timing counts.
  assumes nothing; included by the package and fbp_core.
*/
`ifndef FBP_CFG_SVH
`define FBP_CFG_SVH

// ****************************************
// geometry
// ****************************************
`define FBP_FLASH_BYTES 65536
`define FBP_PAGE_SHIFT 10
`define FBP_BLOCK_SHIFT 11
`define FBP_WORD_SHIFT 2
`define FBP_PROT_BITS 32

// ****************************************
// reset values
// ****************************************
`define FBP_PROT_RESET 32'hFFFFFFFF
`define FBP_USEC_RESET 8'h63

// ****************************************
// interrupt bit positions
// ****************************************
`define FBP_IRQ_PROG 0
`define FBP_IRQ_ACCESS 1

// ****************************************
// operation lengths in microseconds
// ****************************************
`define FBP_PROG_US 20
`define FBP_ERASE_US 20
`define FBP_COMMIT_US 20

`endif

// ---- fbp_pkg.sv ----
/*
  types shared by the flash block protection modules.
  assumes fbp_cfg.svh is on the include path.
*/
`include "fbp_cfg.svh"

package fbp_pkg;

  // ****************************************
  // access kinds and commands
  // ****************************************
  typedef enum logic [1:0] {
    FBP_FETCH = 2'h0,
    FBP_DATA = 2'h1,
    FBP_DEBUG = 2'h2
  } fbp_kind_t;

  typedef enum logic [1:0] {
    FBP_CMD_NONE = 2'h0,
    FBP_CMD_WRITE = 2'h1,
    FBP_CMD_ERASE = 2'h2
  } fbp_cmd_t;

  typedef enum logic [1:0] {
    FBP_IDLE = 2'h0,
    FBP_PROG = 2'h1,
    FBP_ERASE = 2'h3,
    FBP_COMMIT = 2'h2
  } fbp_state_t;

  // ****************************************
  // request carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    fbp_kind_t kind;
    logic [31:0] addr;
  } fbp_rd_req_t;

  typedef struct packed {
    fbp_cmd_t cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } fbp_op_req_t;

endpackage

// ---- fbp_usec_timer.sv ----
/*
  microsecond tick generator: one tick every reload+1 clocks.
  assumes the reload value comes from logic on the same clock.
*/
`timescale 1ns/1ps

module fbp_usec_timer
#(
  parameter int W = 8
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  input wire logic [W-1:0] reload,
  output logic tick
);

  logic [W-1:0] count;

  // ****************************************
  // down counter
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (restart || count == '0)
    begin
      count <= reload;
      tick <= !restart;
    end
    else
    begin
      count <= count - 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

// ---- fbp_core_assertions.sv ----
/* port checker for fbp_core.
   assumes one clock and an async active-high rst. */
`timescale 1ns/1ps
module fbp_core_assertions
(
  input wire logic clock,
  input wire logic rst,
  input wire logic usec_wr,
  input wire logic [7:0] usec_wdata,
  input wire logic [7:0] usec_reload_count,
  input wire logic [31:0] block_program_enable,
  input wire logic [31:0] block_read_enable,
  input wire fbp_pkg::fbp_rd_req_t rd_req,
  input wire logic rd_ready,
  input wire logic rd_done,
  input wire logic [31:0] rd_data,
  input wire logic rd_fault,
  input wire fbp_pkg::fbp_op_req_t op_req,
  input wire logic flash_busy,
  input wire logic commit_start,
  input wire logic commit_bit,
  input wire logic [1:0] irq_raw
);
  import fbp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire tk = rd_req.valid && rd_ready;
  wire re = block_read_enable[rd_req.addr[15:11]];
  wire pe = block_program_enable[op_req.addr[15:11]];
  wire go = rd_ready && !commit_start && op_req.cmd != FBP_CMD_NONE;
  AST_RD_ANSWER: assert property (tk |=> rd_done)
    else $error("read not answered");
  AST_RD_FAULT: assert property (tk && rd_req.kind != FBP_FETCH && !re
    |=> rd_fault && rd_data == 32'h0) else $error("read not refused");
  AST_RD_FETCH: assert property (tk && rd_req.kind == FBP_FETCH
    |=> rd_done && !rd_fault) else $error("fetch refused");
  AST_RD_OPEN: assert property (tk && re |=> !rd_fault)
    else $error("open read refused");
  AST_OP_REFUSE: assert property (go && !pe
    |=> !flash_busy && irq_raw[1]) else $error("op not refused");
  AST_OP_START: assert property (go && pe |=> flash_busy && !rd_ready)
    else $error("op not started");
  AST_ONLY_CLEAR: assert property (((block_program_enable &
    ~$past(block_program_enable)) | (block_read_enable &
    ~$past(block_read_enable))) == 32'h0) else $error("bit set");
  AST_COMMIT: assert property (rd_ready && commit_start
    |=> commit_bit ##[1:1000] !commit_bit) else $error("commit stuck");
  AST_USEC: assert property (usec_wr
    |=> usec_reload_count == $past(usec_wdata)) else $error("usec lost");
endmodule
bind fbp_core fbp_core_assertions chk (.clock(clock), .rst(rst),
  .usec_wr(usec_wr), .usec_wdata(usec_wdata),
  .usec_reload_count(usec_reload_count),
  .block_program_enable(block_program_enable),
  .block_read_enable(block_read_enable), .rd_req(rd_req),
  .rd_ready(rd_ready), .rd_done(rd_done), .rd_data(rd_data),
  .rd_fault(rd_fault), .op_req(op_req), .flash_busy(flash_busy),
  .commit_start(commit_start), .commit_bit(commit_bit), .irq_raw(irq_raw));

// ---- fbp_bus_master.sv ----
/* read master standing for the processor buses and debugger.
   assumes rd_ready is registered on the same clock. */
`timescale 1ns/1ps
module fbp_bus_master
(
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire fbp_pkg::fbp_kind_t kind,
  input wire logic [31:0] addr,
  input wire logic rd_ready,
  output fbp_pkg::fbp_rd_req_t req
);
  import fbp_pkg::*;
  // hold until taken, then leave inverted leftovers on the address
  always_ff @(posedge clock or posedge rst)
    if (rst)
      req <= '{1'b0, FBP_FETCH, 32'h0};
    else if (go)
      req <= '{1'b1, kind, addr};
    else if (req.valid && rd_ready)
      req <= '{1'b0, req.kind, ~req.addr};
endmodule

// ---- fbp_core_tb.sv ----
/* self-checking bench for fbp_core.
   assumes fbp_bus_master as read master and the bound checker. */
`timescale 1ns/1ps
module fbp_core_tb;
  import fbp_pkg::*;
  logic clock = 0, rst = 1, factory_rst = 1, usec_wr = 0, prot_wr = 0;
  logic prot_sel = 0, commit_start = 0, commit_select = 0, go = 0;
  logic rd_ready, rd_done, rd_fault, flash_busy, commit_bit;
  logic [7:0] usec_wdata = 8'h0, usec_reload_count;
  logic [31:0] prot_wdata = 32'h0, addr = 32'h0, rd_data;
  logic [31:0] block_program_enable, block_read_enable;
  logic [1:0] flash_irq_mask_reg = 2'h0, flash_irq_status_clear = 2'h0;
  logic [1:0] irq_raw, irq_masked;
  fbp_kind_t kind = FBP_FETCH;
  fbp_rd_req_t rd_req;
  fbp_op_req_t op_req = '{FBP_CMD_NONE, 32'h0, 32'h0};
  int miscompares = 0, checks_done = 0;
  always #5 clock = ~clock;
  fbp_core #(.FLASH_BYTES(4096), .PROG_US(1), .ERASE_US(1), .COMMIT_US(1))
    uut (.clock, .rst, .factory_rst, .usec_wr, .usec_wdata,
    .usec_reload_count, .prot_wr, .prot_sel, .prot_wdata,
    .block_program_enable, .block_read_enable, .rd_req, .rd_ready,
    .rd_done, .rd_data, .rd_fault, .op_req, .flash_busy, .commit_start,
    .commit_select, .commit_bit, .flash_irq_mask_reg,
    .flash_irq_status_clear, .irq_raw, .irq_masked);
  fbp_bus_master bm (.clock, .rst, .go, .kind, .addr, .rd_ready,
    .req(rd_req));
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic idle;
    for (int n = 0; !rd_ready || flash_busy || commit_bit; n++)
    begin
      if (n > 2000)
      begin
        miscompares++;
        test_done;
      end
      @(posedge clock);
      #1;
    end
  endtask
  task automatic rd(input fbp_kind_t k, input logic [31:0] a);
    idle;
    @(posedge clock);
    go <= 1'b1;
    kind <= k;
    addr <= a;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
    chk(rd_done, 1);
  endtask
  task automatic op(input fbp_cmd_t c, input logic [31:0] a, d);
    idle;
    @(posedge clock);
    op_req <= '{c, a, d};
    @(posedge clock);
    op_req <= '{FBP_CMD_NONE, ~a, ~d};
    #1;
  endtask
  task automatic pw(input logic s, input logic [31:0] d);
    @(posedge clock);
    prot_wr <= 1'b1;
    prot_sel <= s;
    prot_wdata <= d;
    @(posedge clock);
    prot_wr <= 1'b0;
    #1;
  endtask
  task automatic clr;
    @(posedge clock);
    flash_irq_status_clear <= 2'h3;
    @(posedge clock);
    flash_irq_status_clear <= 2'h0;
    #1;
  endtask
  task automatic t_array;
    int n;
    chk({24'h0, usec_reload_count}, 32'h63);
    chk(block_program_enable & block_read_enable, 32'hFFFFFFFF);
    @(posedge clock);
    usec_wdata <= 8'h01;
    usec_wr <= 1'b1;
    @(posedge clock);
    usec_wr <= 1'b0;
    #1;
    chk({24'h0, usec_reload_count}, 32'h1);
    op(FBP_CMD_ERASE, 32'h400, 32'h0);
    chk({flash_busy, rd_ready}, 32'h2);
    for (n = 0; flash_busy && n < 100; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(n, 32'h3);
    idle;
    chk(irq_raw, 32'h1);
    rd(FBP_DATA, 32'h404);
    chk(rd_data, 32'hFFFFFFFF);
    clr;
    chk(irq_raw, 32'h0);
    op(FBP_CMD_WRITE, 32'h404, 32'hA5A50F0F);
    op(FBP_CMD_WRITE, 32'h404, 32'hFFFF00FF);
    rd(FBP_DATA, 32'h404);
    chk(rd_data, 32'hA5A5000F);
    $display("array test done");
  endtask
  task automatic t_prot;
    pw(0, 32'hFFFFFFFE);
    pw(0, 32'hFFFFFFFF);
    chk(block_read_enable, 32'hFFFFFFFE);
    rd(FBP_DATA, 32'h404);
    chk(rd_fault, 1);
    chk(rd_data, 32'h0);
    rd(FBP_DEBUG, 32'h404);
    chk(rd_fault, 1);
    rd(FBP_FETCH, 32'h404);
    chk(rd_data, 32'hA5A5000F);
    rd(FBP_DATA, 32'h808);
    chk(rd_fault, 0);
    clr;
    op(FBP_CMD_WRITE, 32'h404, 32'hFFFFFFFF);
    idle;
    chk(irq_raw, 32'h1);
    @(posedge clock);
    flash_irq_mask_reg <= 2'h2;
    pw(1, 32'hFFFFFFFD);
    op(FBP_CMD_ERASE, 32'h800, 32'h0);
    chk({flash_busy, irq_raw[1], irq_masked[1]}, 32'h3);
    chk(irq_masked, 32'h2);
    clr;
    chk(irq_masked, 32'h0);
    op(FBP_CMD_WRITE, 32'h800, 32'h0);
    chk({flash_busy, irq_raw}, 32'h2);
    $display("protection test done");
  endtask
  task automatic t_commit;
    idle;
    @(posedge clock);
    commit_select <= 1'b1;
    commit_start <= 1'b1;
    @(posedge clock);
    commit_start <= 1'b0;
    #1;
    chk(commit_bit, 1);
    idle;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(block_program_enable, 32'hFFFFFFFD);
    chk(block_read_enable, 32'hFFFFFFFF);
    $display("commit test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    factory_rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_array;
    t_prot;
    t_commit;
    test_done;
  end
endmodule
